// [hdl/pilc_pkg.sv]
package pilc_pkg;
  // ----------------------------------------
  // Pin count and indicator function codes
  // ----------------------------------------
  localparam int PILC_PINS = 3;
  localparam logic [2:0] PILC_FUN_LINK_ACT = 3'h0;
  localparam logic [2:0] PILC_FUN_FAST_ACT = 3'h1;
  localparam logic [2:0] PILC_FUN_ACT_A = 3'h2;
  localparam logic [2:0] PILC_FUN_ACT_B = 3'h3;
  localparam logic [2:0] PILC_FUN_SPLIT = 3'h4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] PILC_DIR_RST = 3'h0;
  localparam logic [2:0] PILC_IRQ_EN_RST = 3'h0;
  localparam logic [2:0] PILC_POL_RST = 3'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint PILC_CLK_HZ = 50000000;
  localparam longint PILC_PULSE_MS = 80;
  localparam longint PILC_PULSE_CYC = (PILC_CLK_HZ * PILC_PULSE_MS) / 1000;
  localparam longint PILC_IRQ_MIN_NS = 40;
  localparam longint PILC_CLK_NS = 20;
  // Least time rounds up
  localparam longint PILC_IRQ_MIN_CYC = (PILC_IRQ_MIN_NS + PILC_CLK_NS - 1) / PILC_CLK_NS;
  localparam int PILC_CNT_W = 24;
endpackage

// [hdl/pilc_pulse.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Stretched pulse: on for a period, then a blank period
// ----------------------------------------
module pilc_pulse
  import pilc_pkg::*;
#(
  parameter int CNT_W = PILC_CNT_W,
  parameter logic [CNT_W-1:0] PERIOD = CNT_W'(PILC_PULSE_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic trig_in,
  output logic pulse_out
);
  typedef enum logic [1:0] {PILC_IDLE, PILC_ON, PILC_BLANK} pilc_pulse_type;
  pilc_pulse_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  wire logic cnt_done = (cnt_q == PERIOD - 1'b1);

  // On-period then a minimum blank before next trigger
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    case (state_q)
      PILC_IDLE: begin
        cnt_d = '0;
        if (trig_in) begin
          state_d = PILC_ON;
        end
      end
      PILC_ON: begin
        if (cnt_done) begin
          state_d = PILC_BLANK;
          cnt_d = '0;
        end
      end
      PILC_BLANK: begin
        if (cnt_done) begin
          state_d = PILC_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = PILC_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= PILC_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign pulse_out = (state_q == PILC_ON);
endmodule
`default_nettype wire

// [hdl/pilc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pilc_top
  import pilc_pkg::*;
#(
  parameter logic [PILC_CNT_W-1:0] PULSE_CYC = PILC_CNT_W'(PILC_PULSE_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] pin_direction_bits_in,
  input wire logic [2:0] pin_data_bits_in,
  input wire logic [2:0] pin_buffer_type_bits_in,
  input wire logic [2:0] pin_irq_polarity_bits_in,
  input wire logic [2:0] pin_irq_enable_in,
  input wire logic [2:0] pin_irq_clear_in,
  input wire logic cfg_write_in,
  input wire logic [2:0] indicator_select_mask_in,
  input wire logic [2:0] indicator_function_code_in,
  input wire logic indicator_cfg_write_in,
  input wire logic [2:0] indicator_select_straps_in,
  input wire logic [2:0] indicator_function_straps_in,
  input wire logic [2:0] indicator_polarity_straps_in,
  input wire logic indicator_global_disable_in,
  input wire logic [2:0] indicator_push_pull_in,
  input wire logic link_up_in,
  input wire logic fast_speed_in,
  input wire logic full_duplex_in,
  input wire logic activity_in,
  input wire logic collision_in,
  input wire logic [2:0] pin_level_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n_out,
  output logic [2:0] pin_input_buf_en_out,
  output logic [2:0] pin_pullup_en_out,
  output logic [2:0] pin_read_data_out,
  output logic [2:0] pin_irq_status_out,
  output logic pin_event_irq_out
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [2:0] dir_q, data_q, buf_q, pol_q, ien_q;
  logic [2:0] sel_q, fun_q, strap_pol_q;
  logic strap_done_q;

  // Config reset constant; straps captured on first clocked edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_q <= PILC_DIR_RST;
      ien_q <= PILC_IRQ_EN_RST;
      pol_q <= PILC_POL_RST;
      data_q <= '0;
      buf_q <= '0;
    end else if (cfg_write_in) begin
      dir_q <= pin_direction_bits_in;
      ien_q <= pin_irq_enable_in;
      pol_q <= pin_irq_polarity_bits_in;
      data_q <= pin_data_bits_in;
      buf_q <= pin_buffer_type_bits_in;
    end
  end

  // Straps are caught after release, never in the async branch
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_done_q <= 1'b0;
      sel_q <= '0;
      fun_q <= '0;
      strap_pol_q <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      sel_q <= indicator_select_straps_in;
      fun_q <= indicator_function_straps_in;
      strap_pol_q <= indicator_polarity_straps_in;
    end else if (indicator_cfg_write_in) begin
      sel_q <= indicator_select_mask_in;
      fun_q <= indicator_function_code_in;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] pin_m_q, pin_s_q;
  logic [4:0] st_m_q, st_s_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Pulled-up idle level, so no false low-level hit after reset
      pin_m_q <= 3'h7;
      pin_s_q <= 3'h7;
      st_m_q <= '0;
      st_s_q <= '0;
    end else begin
      pin_m_q <= pin_level_in;
      pin_s_q <= pin_m_q;
      st_m_q <= {link_up_in, fast_speed_in, full_duplex_in, activity_in, collision_in};
      st_s_q <= st_m_q;
    end
  end
  wire logic link_w = st_s_q[4];
  wire logic fast_w = st_s_q[3];
  wire logic fdx_w = st_s_q[2];
  wire logic act_w = st_s_q[1];
  wire logic col_w = st_s_q[0];

  // ----------------------------------------
  // Pin interrupts
  // ----------------------------------------
  // Level must hold two consecutive samples (PILC_IRQ_MIN_CYC); filters glitches under 40 ns
  logic [2:0] hit_q, sts_q;
  wire logic [2:0] gpio_in_w = ~dir_q & ~sel_q;
  wire logic [2:0] lvl_hit_w = gpio_in_w & ~(pin_s_q ^ pol_q);
  wire logic [2:0] qual_w = lvl_hit_w & hit_q;
  wire logic [2:0] sts_d = qual_w | (sts_q & ~pin_irq_clear_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hit_q <= '0;
      sts_q <= '0;
      pin_event_irq_out <= 1'b0;
    end else begin
      hit_q <= lvl_hit_w;
      sts_q <= sts_d; // set wins over clear
      pin_event_irq_out <= |(sts_d & ien_q);
    end
  end
  assign pin_irq_status_out = sts_q;

  // ----------------------------------------
  // Indicator timing
  // ----------------------------------------
  logic act_pulse_w, col_pulse_w;
  pilc_pulse #(.CNT_W(PILC_CNT_W), .PERIOD(PULSE_CYC)) u_act_pulse (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .trig_in(act_w & link_w),
    .pulse_out(act_pulse_w)
  );
  pilc_pulse #(.CNT_W(PILC_CNT_W), .PERIOD(PULSE_CYC)) u_col_pulse (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .trig_in(col_w & link_w & ~fdx_w),
    .pulse_out(col_pulse_w)
  );

  // Indicator function values (1 = active)
  wire logic f_act = link_w & act_pulse_w;
  wire logic f_link = link_w;
  wire logic f_link_act = link_w & ~act_pulse_w;
  wire logic f_fast_link = link_w & fast_w;
  wire logic f_slow_link = link_w & ~fast_w;
  wire logic f_fast_act = f_fast_link & ~act_pulse_w;
  wire logic f_slow_act = f_slow_link & ~act_pulse_w;
  wire logic f_dpx = link_w & (fdx_w | col_pulse_w);
  wire logic f_speed = link_w & fast_w;

  // Function code mapping; pin 0 for codes 0-3 uses slow link/act and speed
  logic [2:0] ind_on;
  always_comb begin
    ind_on = '0;
    case (fun_q)
      PILC_FUN_LINK_ACT: ind_on = {f_link_act, f_dpx, f_slow_act};
      PILC_FUN_FAST_ACT: ind_on = {f_fast_act, f_dpx, f_speed};
      PILC_FUN_ACT_A: ind_on = {f_act, f_link, f_slow_act};
      PILC_FUN_ACT_B: ind_on = {f_act, f_link, f_speed};
      PILC_FUN_SPLIT: ind_on = {f_act, f_slow_link, f_fast_link};
      default: ind_on = '0; // Reserved codes stay inactive
    endcase
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Active level is opposite of hard strap
  wire logic [2:0] ind_act_w = ind_on & {3{~indicator_global_disable_in}};
  wire logic [2:0] ind_val_w = ~strap_pol_q;
  // Push-pull inactive drives strap level; open-drain floats
  wire logic [2:0] ind_drv_w = ind_act_w | indicator_push_pull_in;
  // Inactive level is the strap level, the lamp's off state
  wire logic [2:0] ind_lvl_w = (ind_act_w & ind_val_w) | (~ind_act_w & strap_pol_q);
  wire logic [2:0] gp_drv_w = dir_q & (~buf_q | ~data_q);
  wire logic [2:0] drv_d = (sel_q & ind_drv_w) | (~sel_q & gp_drv_w);
  wire logic [2:0] lvl_d = (sel_q & ind_lvl_w) | (~sel_q & data_q);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_n_out <= 3'h7;
      pin_input_buf_en_out <= 3'h7;
      pin_pullup_en_out <= 3'h7;
      pin_read_data_out <= '0;
    end else begin
      pin_out <= lvl_d;
      pin_oe_n_out <= ~drv_d;
      pin_input_buf_en_out <= ~dir_q & ~sel_q;
      pin_pullup_en_out <= ~sel_q;
      pin_read_data_out <= (dir_q & data_q) | (~dir_q & pin_s_q);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_reset_dir_clear: assert property (@(posedge clk_in)
    $fell(rst_in) |-> dir_q == '0 && ien_q == '0 && pol_q == '0)
    else $error("config not cleared by reset");
  chk_opendrain_float: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_write_in && !sel_q[0] && pin_direction_bits_in[0] && pin_buffer_type_bits_in[0] && pin_data_bits_in[0])
    |=> ##1 pin_oe_n_out[0])
    else $error("open-drain high drove pin");
  chk_opendrain_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (!sel_q[0] && dir_q[0] && buf_q[0] && !data_q[0]) |=> !pin_oe_n_out[0] && !pin_out[0])
    else $error("open-drain low not driven");
  chk_pushpull_level: assert property (@(posedge clk_in) disable iff (rst_in)
    (!sel_q[1] && dir_q[1] && !buf_q[1]) |=> !pin_oe_n_out[1] && pin_out[1] == $past(data_q[1]))
    else $error("push-pull level wrong");
  chk_input_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    !dir_q[1] |=> pin_read_data_out[1] == $past(pin_s_q[1]))
    else $error("input read data wrong");
  chk_inbuf_off_out: assert property (@(posedge clk_in) disable iff (rst_in)
    dir_q[2] |=> !pin_input_buf_en_out[2])
    else $error("input buffer on for output");
  chk_buftype_input: assert property (@(posedge clk_in) disable iff (rst_in)
    (!dir_q[1] && !sel_q[1]) |=> pin_oe_n_out[1])
    else $error("input pin driven");
  // Status stays until cleared; a clear with no new hit empties it
  chk_status_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    (sts_q[1] && !pin_irq_clear_in[1]) |=> sts_q[1])
    else $error("status lost without clear");
  chk_status_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (pin_irq_clear_in[0] && !qual_w[0]) |=> !sts_q[0])
    else $error("status not cleared");
  chk_irq_combine: assert property (@(posedge clk_in) disable iff (rst_in)
    pin_event_irq_out == |(sts_q & $past(ien_q)))
    else $error("combined request wrong");
  chk_irq_min_width: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(sts_q[0]) |-> $past(lvl_hit_w[0], 1) && $past(lvl_hit_w[0], 2))
    else $error("status set by short level");
  chk_polarity_high: assert property (@(posedge clk_in) disable iff (rst_in)
    (gpio_in_w[1] && pol_q[1] && pin_s_q[1] && hit_q[1]) |=> sts_q[1])
    else $error("high level did not set status");
  // ----------------------------------------
  // Indicator checks
  // ----------------------------------------
  chk_ind_pullup_off: assert property (@(posedge clk_in) disable iff (rst_in)
    sel_q[2] |=> !pin_pullup_en_out[2] && !pin_input_buf_en_out[2])
    else $error("indicator pull-up or buffer on");
  chk_strap_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(strap_done_q) |-> sel_q == $past(indicator_select_straps_in)
      && fun_q == $past(indicator_function_straps_in))
    else $error("straps not loaded");
  chk_ind_disable: assert property (@(posedge clk_in) disable iff (rst_in)
    (indicator_global_disable_in && sel_q[0] && !indicator_push_pull_in[0]) |=> pin_oe_n_out[0])
    else $error("disabled indicator driven");
  chk_reserved_code: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_q > PILC_FUN_SPLIT) |-> ind_on == '0)
    else $error("reserved code active");
  // Active level must be the inverse of the hard strap
  chk_ind_active_level: assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_q[2] && ind_act_w[2]) |=> !pin_oe_n_out[2] && pin_out[2] == !$past(strap_pol_q[2]))
    else $error("indicator active level wrong");
  chk_ind_idle_float: assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_q[2] && !ind_act_w[2] && !indicator_push_pull_in[2]) |=> pin_oe_n_out[2])
    else $error("inactive indicator driven");
  chk_nolink_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    !link_w |-> !f_act && !f_link_act && !f_dpx && !f_speed)
    else $error("indicator function active without link");
  chk_link_steady: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_q == PILC_FUN_ACT_A && !link_w) |-> ind_on == '0)
    else $error("indicator active without link");
  chk_speed_level: assert property (@(posedge clk_in) disable iff (rst_in)
    (fun_q == PILC_FUN_ACT_B) |-> ind_on[0] == (link_w && fast_w))
    else $error("speed indicator wrong");
  // Main scenarios worth seeing at least once
  cov_irq_fire: cover property (@(posedge clk_in) disable iff (rst_in) $rose(pin_event_irq_out));
  cov_act_pulse: cover property (@(posedge clk_in) disable iff (rst_in) $rose(act_pulse_w));
  cov_col_pulse: cover property (@(posedge clk_in) disable iff (rst_in) $rose(col_pulse_w));
  cov_ind_disabled: cover property (@(posedge clk_in) disable iff (rst_in) indicator_global_disable_in && |sel_q);
endmodule
`default_nettype wire

// [sim/pilc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Outside pins: device drive, outside source, pull-up
// ----------------------------------------
module pilc_pin_model (
  input wire logic clk_in,
  input wire logic [2:0] pin_in,
  input wire logic [2:0] pin_oe_n_in,
  input wire logic [2:0] pin_pullup_en_in,
  input wire logic [2:0] ext_drive_in,
  input wire logic [2:0] ext_value_in,
  output logic [2:0] level_out
);
  logic [2:0] last_q = 3'h0;
  logic [2:0] float_d;
  // A bare floating pin flips each cycle so no settled guess can pass
  assign float_d = pin_pullup_en_in | ~last_q;
  // Device wins, then the outside source, then pull-up or float
  assign level_out = (~pin_oe_n_in & pin_in) | (pin_oe_n_in & ext_drive_in & ext_value_in)
                   | (pin_oe_n_in & ~ext_drive_in & float_d);
  // Last level, for the floating case
  always @(posedge clk_in) begin
    last_q <= level_out;
  end
endmodule
`default_nettype wire

// [sim/pilc_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pilc_top_tb_top;
  import pilc_pkg::*;
  localparam int PCYC = 20;
  localparam logic [2:0] POL_STRAP = 3'h5;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] dir = 3'h0, dat = 3'h0, bt = 3'h0, pol = 3'h0, ien = 3'h0, iclr = 3'h0;
  logic [2:0] mask = 3'h0, code = 3'h0, pp = 3'h0, ext_drv = 3'h0, ext_val = 3'h0;
  logic cfg_wr = 1'b0, ind_wr = 1'b0, gdis = 1'b0;
  logic link = 1'b0, fast = 1'b1, fdx = 1'b1, act = 1'b0, col = 1'b0;
  logic [2:0] lvl, pout, oen, ibuf, pup, rdat, ists;
  logic irq;
  logic [8:0] tbl [10];
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // ----------------------------------------
  // Design and pins
  // ----------------------------------------
  pilc_top #(.PULSE_CYC(PILC_CNT_W'(PCYC))) pilc_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .pin_direction_bits_in(dir), .pin_data_bits_in(dat), .pin_buffer_type_bits_in(bt),
    .pin_irq_polarity_bits_in(pol), .pin_irq_enable_in(ien), .pin_irq_clear_in(iclr),
    .cfg_write_in(cfg_wr), .indicator_select_mask_in(mask), .indicator_function_code_in(code),
    .indicator_cfg_write_in(ind_wr), .indicator_select_straps_in(3'h4),
    .indicator_function_straps_in(3'h2), .indicator_polarity_straps_in(POL_STRAP),
    .indicator_global_disable_in(gdis), .indicator_push_pull_in(pp), .link_up_in(link),
    .fast_speed_in(fast), .full_duplex_in(fdx), .activity_in(act), .collision_in(col),
    .pin_level_in(lvl), .pin_out(pout), .pin_oe_n_out(oen), .pin_input_buf_en_out(ibuf),
    .pin_pullup_en_out(pup), .pin_read_data_out(rdat), .pin_irq_status_out(ists),
    .pin_event_irq_out(irq));
  pilc_pin_model pilc_pin_model_inst (.clk_in(clk_in), .pin_in(pout), .pin_oe_n_in(oen),
    .pin_pullup_en_in(pup), .ext_drive_in(ext_drv), .ext_value_in(ext_val), .level_out(lvl));
  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  always #10 clk_in = ~clk_in;
  // Whole run is well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("FAIL t=%0t timeout", $time);
      print_verdict();
    end
  end
  task automatic wc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] d, input logic [2:0] v, input logic [2:0] b,
                     input logic [2:0] p, input logic [2:0] e);
    dir = d;
    dat = v;
    bt = b;
    pol = p;
    ien = e;
    cfg_wr = 1'b1;
    wc(1);
    cfg_wr = 1'b0;
    wc(8);
  endtask
  task automatic ind(input logic [2:0] m, input logic [2:0] c);
    mask = m;
    code = c;
    ind_wr = 1'b1;
    wc(1);
    ind_wr = 1'b0;
    wc(8);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Code, link, fast, full duplex, expected active pins
    tbl = '{9'b000_111_110, 9'b001_111_111, 9'b010_111_010, 9'b011_111_011, 9'b100_111_001,
            9'b100_101_010, 9'b001_101_010, 9'b000_011_000, 9'b101_111_000, 9'b000_110_100};
    wc(5);
    rst_in = 1'b0;
    wc(4);
    chk("oe_n after reset", oen, 3'h7);
    chk("input buffers", ibuf, 3'h3);
    chk("pull-ups", pup, 3'h3);
    // Low level with default polarity sets status but no request
    ext_drv = 3'h1;
    wc(8);
    chk("status low level", ists, 3'h1);
    chk("request masked", {2'h0, irq}, 3'h0);
    chk("input read", {1'b0, rdat[1:0]}, 3'h2);
    ext_drv = 3'h0;
    wc(5);
    iclr = 3'h7;
    wc(1);
    iclr = 3'h0;
    wc(2);
    chk("status cleared", ists, 3'h0);
    // High polarity on pulled-up pin 1, enabled
    cfg(3'h0, 3'h0, 3'h0, 3'h2, 3'h2);
    chk("status high level", ists, 3'h2);
    chk("request", {2'h0, irq}, 3'h1);
    cfg(3'h0, 3'h0, 3'h0, 3'h2, 3'h0);
    chk("request disabled", {2'h0, irq}, 3'h0);
    // Pin 0 open-drain low, pin 1 push-pull high
    cfg(3'h3, 3'h2, 3'h1, 3'h0, 3'h0);
    chk("outputs oe_n", oen, 3'h4);
    chk("outputs level", {1'b0, pout[1:0]}, 3'h2);
    chk("outputs inbuf", ibuf, 3'h0);
    chk("outputs pullup", pup, 3'h3);
    chk("outputs read", {1'b0, rdat[1:0]}, 3'h2);
    cfg(3'h3, 3'h3, 3'h1, 3'h0, 3'h0);
    chk("open-drain release", oen, 3'h5);
    cfg(3'h0, 3'h3, 3'h3, 3'h0, 3'h0);
    chk("buffer type on inputs", oen, 3'h7);
    // Indicator function table, all open-drain
    for (int i = 0; i < 10; i++) begin
      link = tbl[i][5];
      fast = tbl[i][4];
      fdx = tbl[i][3];
      ind(3'h7, tbl[i][8:6]);
      chk("active pins", ~oen, tbl[i][2:0]);
      chk("active level", pout & tbl[i][2:0], ~POL_STRAP & tbl[i][2:0]);
    end
    chk("indicator pull-ups", pup | ibuf, 3'h0);
    // Activity blinks pin 2 off, collision blinks pin 1 on
    act = 1'b1;
    col = 1'b1;
    wc(1);
    act = 1'b0;
    col = 1'b0;
    wc(8);
    chk("pulses on", ~oen, 3'h2);
    wc(PCYC + 10);
    chk("pulses over", ~oen, 3'h4);
    ind(3'h7, 3'h2);
    act = 1'b1;
    wc(1);
    act = 1'b0;
    wc(8);
    chk("activity pulse", ~oen, 3'h6);
    wc(PCYC + 10);
    chk("activity idle", ~oen, 3'h2);
    // Global disable: open-drain floats, push-pull held inactive
    pp = 3'h2;
    gdis = 1'b1;
    ind(3'h7, 3'h4);
    chk("disabled oe_n", oen, 3'h5);
    chk("disabled level", {2'h0, pout[1]}, {2'h0, POL_STRAP[1]});
    // Mid-run reset must clear direction, enable and polarity again
    cfg(3'h3, 3'h0, 3'h0, 3'h2, 3'h2);
    rst_in = 1'b1;
    wc(2);
    rst_in = 1'b0;
    wc(8);
    chk("reset oe_n", oen, 3'h7);
    chk("reset inbuf", ibuf, 3'h3);
    chk("reset status", ists, 3'h0);
    chk("reset request", {2'h0, irq}, 3'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
